//--- design/mstc_top.sv
// Behaviour
// - reset loads Home position and polarities, zero levels; supply mode at full step gives slow decay on both bridges
// - each advance rising edge outside translator reset and faults moves translator one increment, levels and polarities
// - falling level selects mixed decay, equal or rising selects slow
// - selects: LL full, HL 1/8, HH 1/16, LH 1/128
// - resolution change applies only at next advance rising edge
// - thermal shutdown or overcurrent returns translator to Home
// - mixed decay: fast for first 31.25% of off time, then slow
// - off mode ground: 30 us off time, always mixed decay
// - off mode supply: 30 us, automatic decay, full step forces slow
// - resistor mode: off time is the control us field in us (zero keeps 30 us), automatic, full step slow
// - translator reset holds Home, outputs off, advance pulses ignored
// - rotation input sets direction, applied at next advance rising edge
// - on phase drives diagonal pair; trip clears latch and starts decay
// - off interval timed by one-shot started at trip, length from setting
// - level code scales peak trip current by step percentage
// - comparators masked about 1 us after each switching event
// - Home is 45 degrees forward; currents follow sine and cosine
// - output disable turns bridges off, translator keeps running
`timescale 1ns/1ps
`default_nettype none
module mstc_top #(
    parameter int OFF_CYC_P   = mstc_pkg::OFF_CYC,
    parameter int BLANK_CYC_P = mstc_pkg::BLANK_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    // translator pins
    input  wire logic        advance_in,
    input  wire logic        rotation_in,
    input  wire logic        resolution_sel_a,
    input  wire logic        resolution_sel_b,
    input  wire logic        translator_reset_n,
    input  wire logic        output_disable,
    // fault inputs
    input  wire logic        thermal_shutdown,
    input  wire logic        overcurrent,
    // per bridge
    input  wire logic [1:0]  cmp_trip,
    output var  logic [7:0]  phase_level [2],
    output var  logic [1:0]  phase_pol,
    output var  logic [1:0]  bridge_drive,
    output var  logic [1:0]  bridge_fast,
    output var  logic [1:0]  bridge_slow
);
    import mstc_pkg::*;

    if (OFF_CYC_P < 2 || OFF_CYC_P > 65535 || BLANK_CYC_P < 1 || BLANK_CYC_P > 255) begin : g_chk
        $error("mstc_top: off or blank count out of range");
    end

    // ----------------------------------------
    // level lookup
    // ----------------------------------------
    function automatic logic [7:0] level_of(input logic [7:0] x);
        logic [5:0] b;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [9:0] prod;
        b    = x[7:2];
        lo   = SINE_TAB[int'(b) * 8 +: 8];
        hi   = (b == TAB_LAST) ? lo : SINE_TAB[(int'(b) + 1) * 8 +: 8];
        prod = 10'((hi - lo) * x[1:0]);
        return 8'(lo + 8'(prod >> 2));
    endfunction : level_of

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    logic        hreadyout_r;
    logic [31:0] hrdata_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] ctrl_r;
    logic [31:0] status_w;
    logic [31:0] rd_w;
    wire         acc_w  = hsel & hready & htrans[1];
    wire         rd_acc = acc_w & ~hwrite;
    wire         wr_acc = acc_w & hwrite;

    assign rd_w = (haddr[7:0] == CTRL_OFS) ? ctrl_r :
                  (haddr[7:0] == STATUS_OFS) ? status_w : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            hrdata_r    <= 32'h0000_0000;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            ctrl_r      <= CTRL_RESET;
        end else begin
            hrdata_r  <= rd_acc ? rd_w : 32'h0000_0000;
            wr_pend_r <= wr_acc;
            if (wr_acc) begin
                wr_addr_r <= haddr[7:0];
            end
            if (wr_pend_r && wr_addr_r == CTRL_OFS) begin
                ctrl_r <= {16'h0000, hwdata[CTRL_US_LO +: 8], 6'h00, hwdata[CTRL_MODE_LO +: 2]};
            end
        end
    end
    assign hreadyout = hreadyout_r;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic       adv_prev_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r    <= 4'h0;
            sync2_r    <= 4'h0;
            adv_prev_r <= 1'b0;
        end else begin
            sync1_r    <= {resolution_sel_b, resolution_sel_a, rotation_in, advance_in};
            sync2_r    <= sync1_r;
            adv_prev_r <= sync2_r[0];
        end
    end
    wire adv_rise = sync2_r[0] & ~adv_prev_r;

    // ----------------------------------------
    // translator
    // ----------------------------------------
    logic [8:0] pos_r;
    logic [1:0] res_r;
    logic       dir_r;
    logic       step_seen_r;
    logic [1:0] res_w;
    logic [8:0] inc_w;
    wire        fault_w   = thermal_shutdown | overcurrent;
    wire        go_home_w = ~translator_reset_n | fault_w;
    wire        do_step_w = adv_rise & ~go_home_w;

    assign res_w = {sync2_r[3], sync2_r[2]} == 2'b01 ? MSTC_RES_8 :
                   {sync2_r[3], sync2_r[2]} == 2'b11 ? MSTC_RES_16 :
                   {sync2_r[3], sync2_r[2]} == 2'b10 ? MSTC_RES_128 :
                   MSTC_RES_FULL;
    assign inc_w = res_w == MSTC_RES_8 ? INC_8 :
                   res_w == MSTC_RES_16 ? INC_16 :
                   res_w == MSTC_RES_128 ? INC_128 : INC_FULL;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_r       <= HOME_POS;
            res_r       <= MSTC_RES_FULL;
            dir_r       <= 1'b1;
            step_seen_r <= 1'b0;
        end else begin
            step_seen_r <= do_step_w;
            if (go_home_w) begin
                pos_r <= HOME_POS;
            end else if (do_step_w) begin
                res_r <= res_w;
                dir_r <= sync2_r[1];
                pos_r <= sync2_r[1] ? 9'(pos_r + inc_w) : 9'(pos_r - inc_w);
            end
        end
    end

    // ----------------------------------------
    // phase levels and polarities
    // ----------------------------------------
    logic [7:0] q_w;
    logic [7:0] qc_w;
    logic [7:0] lvl_w [2];
    logic [1:0] pol_w;
    logic [7:0] lvl_r [2];
    logic [1:0] pol_r;
    logic [1:0] auto_mix_r;
    assign q_w      = {1'b0, pos_r[6:0]};
    assign qc_w     = 8'(QUAD_SPAN - q_w);
    assign lvl_w[0] = level_of(pos_r[7] ? q_w : qc_w);
    assign lvl_w[1] = level_of(pos_r[7] ? qc_w : q_w);
    assign pol_w[0] = pos_r[8] == pos_r[7];
    assign pol_w[1] = ~pos_r[8];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_r      <= '{8'h00, 8'h00};
            pol_r      <= 2'h3;
            auto_mix_r <= 2'h3;
        end else begin
            lvl_r <= lvl_w;
            pol_r <= pol_w;
            if (go_home_w) begin
                auto_mix_r <= 2'h3;
            end else if (step_seen_r) begin
                auto_mix_r <= {lvl_w[1] < lvl_r[1], lvl_w[0] < lvl_r[0]};
            end
        end
    end
    assign phase_level = lvl_r;
    assign phase_pol   = pol_r;

    // ----------------------------------------
    // off time selection
    // ----------------------------------------
    wire  [1:0]  mode_w = ctrl_r[CTRL_MODE_LO +: 2];
    wire  [7:0]  us_w   = ctrl_r[CTRL_US_LO +: 8];
    logic [15:0] off_cyc_w;
    logic [15:0] fast_cyc_w;
    logic [1:0]  eff_mix_w;
    assign off_cyc_w  = (mode_w == MODE_RES && us_w != 8'h00) ?
                        16'(int'(us_w) * CYC_PER_US) : 16'(OFF_CYC_P);
    assign fast_cyc_w = 16'((int'(off_cyc_w) * FAST_NUM) >> FAST_SHIFT);
    assign eff_mix_w  = (mode_w == MODE_GND) ? 2'h3 :
                        (res_r == MSTC_RES_FULL) ? 2'h0 : auto_mix_r;

    assign status_w = {7'h00, dir_r, 2'h0, eff_mix_w, 2'h0, res_r, 7'h00, pos_r};

    // ----------------------------------------
    // chopper per bridge
    // ----------------------------------------
    wire drv_ok_w = translator_reset_n & ~output_disable & ~fault_w;
    mstc_ch_t    ch_r       [2];
    logic [7:0]  blank_r    [2];
    logic [15:0] off_r      [2];
    logic [15:0] fast_r     [2];
    logic [1:0]  drive_r;
    logic [1:0]  fast_o_r;
    logic [1:0]  slow_o_r;

    for (genvar i = 0; i < 2; i++) begin : g_br
        mstc_ch_t    ch_nxt;
        logic [7:0]  blank_nxt;
        logic [15:0] off_nxt;
        logic [15:0] fast_nxt;
        always_comb begin
            ch_nxt    = ch_r[i];
            blank_nxt = (blank_r[i] != 8'h00) ? 8'(blank_r[i] - 8'h01) : 8'h00;
            off_nxt   = off_r[i];
            fast_nxt  = fast_r[i];
            case (ch_r[i])
                MSTC_CH_IDLE: begin
                    if (drv_ok_w) begin
                        ch_nxt    = MSTC_CH_ON;
                        blank_nxt = 8'(BLANK_CYC_P);
                    end
                end
                MSTC_CH_ON: begin
                    if (!drv_ok_w) begin
                        ch_nxt = MSTC_CH_IDLE;
                    end else if (blank_r[i] == 8'h00 && cmp_trip[i]) begin
                        ch_nxt    = MSTC_CH_DECAY;
                        blank_nxt = 8'(BLANK_CYC_P);
                        off_nxt   = off_cyc_w;
                        fast_nxt  = eff_mix_w[i] ? fast_cyc_w : 16'h0000;
                    end
                end
                MSTC_CH_DECAY: begin
                    off_nxt  = 16'(off_r[i] - 16'h0001);
                    fast_nxt = (fast_r[i] != 16'h0000) ? 16'(fast_r[i] - 16'h0001) : 16'h0000;
                    if (!drv_ok_w) begin
                        ch_nxt = MSTC_CH_IDLE;
                    end else if (off_r[i] <= 16'h0001) begin
                        ch_nxt    = MSTC_CH_ON;
                        blank_nxt = 8'(BLANK_CYC_P);
                    end
                end
                default: begin
                    ch_nxt = MSTC_CH_IDLE;
                end
            endcase
        end
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ch_r[i]     <= MSTC_CH_IDLE;
                blank_r[i]  <= 8'h00;
                off_r[i]    <= 16'h0000;
                fast_r[i]   <= 16'h0000;
                drive_r[i]  <= 1'b0;
                fast_o_r[i] <= 1'b0;
                slow_o_r[i] <= 1'b0;
            end else begin
                ch_r[i]     <= ch_nxt;
                blank_r[i]  <= blank_nxt;
                off_r[i]    <= off_nxt;
                fast_r[i]   <= fast_nxt;
                drive_r[i]  <= ch_nxt == MSTC_CH_ON;
                fast_o_r[i] <= ch_nxt == MSTC_CH_DECAY && fast_nxt != 16'h0000;
                slow_o_r[i] <= ch_nxt == MSTC_CH_DECAY && fast_nxt == 16'h0000;
            end
        end
    end
    assign bridge_drive = drive_r;
    assign bridge_fast  = fast_o_r;
    assign bridge_slow  = slow_o_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    home_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !translator_reset_n |=> pos_r == HOME_POS && bridge_drive == 2'h0)
        else $error("translator not at home under reset");
    one_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        do_step_w && sync2_r[1] |=> pos_r == 9'($past(pos_r) + $past(inc_w)))
        else $error("forward step size wrong");
    fault_home_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fault_w |=> pos_r == HOME_POS)
        else $error("fault did not return home");
    res_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !do_step_w |=> $stable(res_r) && $stable(dir_r))
        else $error("resolution or direction changed without step");
    decay_pick_a: assert property (@(posedge hclk) disable iff (!hresetn)
        step_seen_r && !go_home_w |=> auto_mix_r[0] == ($past(lvl_w[0]) < $past(lvl_r[0])))
        else $error("automatic decay choice wrong");
    out_disable_a: assert property (@(posedge hclk) disable iff (!hresetn)
        output_disable |=> bridge_drive == 2'h0 && bridge_fast == 2'h0 && bridge_slow == 2'h0)
        else $error("bridge driven while disabled");
    blank_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ch_r[0] == MSTC_CH_ON && blank_r[0] != 8'h00 |=> ch_r[0] != MSTC_CH_DECAY)
        else $error("trip accepted inside blank time");
    gnd_fast_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ch_r[0] == MSTC_CH_ON && blank_r[0] == 8'h00 && cmp_trip[0] && drv_ok_w && mode_w == MODE_GND
        |=> bridge_fast[0] && off_r[0] == off_cyc_w)
        else $error("ground mode decay not fast first");
    full_slow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ch_r[1] == MSTC_CH_ON && blank_r[1] == 8'h00 && cmp_trip[1] && drv_ok_w
        && mode_w != MODE_GND && res_r == MSTC_RES_FULL |=> bridge_slow[1])
        else $error("full step decay not slow");
endmodule : mstc_top
`default_nettype wire

//--- shared/mstc_pkg.sv
package mstc_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int OFF_TIME_US   = 30;
    localparam int BLANK_TIME_NS = 1000;
    localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;
    localparam int OFF_CYC       = (OFF_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int BLANK_CYC     = BLANK_TIME_NS / CLK_PERIOD_NS;
    localparam int FAST_NUM      = 5;
    localparam int FAST_SHIFT    = 4;
    // ----------------------------------------
    // translator
    // ----------------------------------------
    localparam logic [8:0] HOME_POS  = 9'h040;
    localparam logic [8:0] INC_FULL  = 9'h080;
    localparam logic [8:0] INC_8     = 9'h010;
    localparam logic [8:0] INC_16    = 9'h008;
    localparam logic [8:0] INC_128   = 9'h001;
    localparam logic [7:0] QUAD_SPAN = 8'h80;
    localparam logic [5:0] TAB_LAST  = 6'h20;
    localparam logic [263:0] SINE_TAB =
        264'hFFFF_FEFC_FAF7_F4F0_ECE7_E1DB_D4CD_C5BD_B4AB_A298_8E83_786D_6256_4A3E_3225_190D_00;
    typedef enum logic [1:0] {
        MSTC_RES_FULL = 2'h0,
        MSTC_RES_8    = 2'h1,
        MSTC_RES_16   = 2'h2,
        MSTC_RES_128  = 2'h3
    } mstc_res_t;
    typedef enum logic [2:0] {
        MSTC_CH_IDLE  = 3'h1,
        MSTC_CH_ON    = 3'h2,
        MSTC_CH_DECAY = 3'h4
    } mstc_ch_t;
    // ----------------------------------------
    // registers
    // ----------------------------------------
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  STATUS_OFS   = 8'h04;
    localparam int          CTRL_MODE_LO = 0;
    localparam int          CTRL_US_LO   = 8;
    localparam logic [1:0]  MODE_GND     = 2'h0;
    localparam logic [1:0]  MODE_VDD     = 2'h1;
    localparam logic [1:0]  MODE_RES     = 2'h2;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_1E01;
    localparam int          ST_RES_LO    = 16;
    localparam int          ST_MIX_LO    = 20;
    localparam int          ST_DIR       = 24;
endpackage : mstc_pkg

//--- verif/mstc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mstc_ctrl_model (
    // clock
    input  wire logic hclk,
    // step link
    output var  logic advance_in,
    output var  logic rotation_in,
    output var  logic resolution_sel_a,
    output var  logic resolution_sel_b
);
    initial begin
        advance_in       = 1'b0;
        rotation_in      = 1'b1;
        resolution_sel_a = 1'b0;
        resolution_sel_b = 1'b0;
    end
    // ----------------------------------------
    // set direction and selects, optional pulse
    // ----------------------------------------
    task automatic step(input logic dir, input logic [1:0] sel, input logic pulse);
        @(posedge hclk);
        rotation_in      <= dir;
        resolution_sel_a <= sel[1];
        resolution_sel_b <= sel[0];
        repeat (2) @(posedge hclk);
        if (pulse) begin
            advance_in <= 1'b1;
            repeat (3) @(posedge hclk);
            advance_in <= 1'b0;
        end
        repeat (4) @(posedge hclk);
    endtask : step
endmodule : mstc_ctrl_model
`default_nettype wire

//--- verif/microstep_translator_chopper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module microstep_translator_chopper_tb;
    import mstc_pkg::*;
    localparam int         OFF_T    = 16;
    localparam int         BLANK_T  = 4;
    localparam int         WAKE_CYC = 1000000 / CLK_PERIOD_NS;
    localparam logic [7:0] HOME_LVL = 8'hB4; // 70.71% of 255
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        advance_in;
    logic        rotation_in;
    logic        sel_a;
    logic        sel_b;
    logic        translator_reset_n;
    logic        output_disable;
    logic        thermal_shutdown;
    logic        overcurrent;
    logic [1:0]  cmp_trip;
    logic [7:0]  phase_level [2];
    logic [1:0]  phase_pol;
    logic [1:0]  bridge_drive;
    logic [1:0]  bridge_fast;
    logic [1:0]  bridge_slow;
    logic [8:0]  exp_pos;
    logic [31:0] rd;
    int          bad_count;
    int          total_checks;
    int          cycles;
    assign hready = hreadyout;
    // ----------------------------------------
    // instances
    // ----------------------------------------
    mstc_top #(.OFF_CYC_P(OFF_T), .BLANK_CYC_P(BLANK_T)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .advance_in(advance_in), .rotation_in(rotation_in), .resolution_sel_a(sel_a),
        .resolution_sel_b(sel_b), .translator_reset_n(translator_reset_n),
        .output_disable(output_disable), .thermal_shutdown(thermal_shutdown),
        .overcurrent(overcurrent), .cmp_trip(cmp_trip), .phase_level(phase_level),
        .phase_pol(phase_pol), .bridge_drive(bridge_drive), .bridge_fast(bridge_fast),
        .bridge_slow(bridge_slow));
    mstc_ctrl_model u_ctrl (.hclk(hclk), .advance_in(advance_in), .rotation_in(rotation_in),
        .resolution_sel_a(sel_a), .resolution_sel_b(sel_b));
    initial hclk = 1'b0;
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            conclude();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : ahb
    task automatic pos_chk(input logic [8:0] p);
        ahb(1'b0, 32'h4, 32'h0, rd);
        chk({23'h0, rd[8:0]}, {23'h0, p});
    endtask : pos_chk
    task automatic chop(input int b, input int fexp, input int oexp);
        int n;
        int f;
        int s;
        n = 0;
        f = 0;
        s = 0;
        do @(posedge hclk); while (bridge_drive[b] !== 1'b1);
        repeat (BLANK_T + 2) @(posedge hclk);
        cmp_trip[b] <= 1'b1;
        @(posedge hclk);
        cmp_trip[b] <= 1'b0;
        #1;
        n = 0;
        while (bridge_drive[b] !== 1'b1 && n < 2000) begin
            f += int'(bridge_fast[b] === 1'b1);
            s += int'(bridge_slow[b] === 1'b1);
            n++;
            @(posedge hclk);
            #1;
        end
        chk(32'(n), 32'(oexp));
        chk(32'(f), 32'(fexp));
        chk(32'(s), 32'(oexp - fexp));
        @(posedge hclk);
        cmp_trip[b] <= 1'b1;
        @(posedge hclk);
        cmp_trip[b] <= 1'b0;
        @(posedge hclk);
        #1;
        chk({31'h0, bridge_drive[b]}, 32'h1);
    endtask : chop
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_home;
        exp_pos = 9'h040;
        pos_chk(exp_pos);
        chk({16'h0000, phase_level[1], phase_level[0]}, {16'h0000, HOME_LVL, HOME_LVL});
        chk({30'h0, phase_pol}, 32'h3);
        ahb(1'b0, 32'h0, 32'h0, rd);
        chk(rd, CTRL_RESET);
        ahb(1'b0, 32'h10, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'b1, 32'h4, 32'hFFFF_FFFF, rd);
        pos_chk(exp_pos);
        $display("test home done");
    endtask : t_home
    task automatic t_res;
        logic [1:0] sel_tab [4];
        logic [8:0] inc_tab [4];
        sel_tab = '{2'b00, 2'b10, 2'b11, 2'b01};
        inc_tab = '{9'h080, 9'h010, 9'h008, 9'h001};
        repeat (WAKE_CYC) @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            u_ctrl.step(1'b1, sel_tab[i], 1'b1);
            exp_pos = exp_pos + inc_tab[i];
            pos_chk(exp_pos);
            chk({30'h0, rd[17:16]}, 32'(i));
        end
        u_ctrl.step(1'b0, 2'b00, 1'b0);
        pos_chk(exp_pos);
        chk({30'h0, rd[17:16]}, 32'h3);
        chk({31'h0, rd[24]}, 32'h1);
        u_ctrl.step(1'b0, 2'b00, 1'b1);
        exp_pos = exp_pos - 9'h080;
        pos_chk(exp_pos);
        chk({30'h0, rd[17:16]}, 32'h0);
        chk({31'h0, rd[24]}, 32'h0);
        $display("test resolution done");
    endtask : t_res
    task automatic t_decay;
        @(posedge hclk);
        translator_reset_n <= 1'b0;
        u_ctrl.step(1'b1, 2'b00, 1'b1);
        pos_chk(9'h040);
        chk({30'h0, bridge_drive}, 32'h0);
        translator_reset_n <= 1'b1;
        u_ctrl.step(1'b1, 2'b00, 1'b1);
        pos_chk(9'h0C0);
        chk({30'h0, rd[21:20]}, 32'h0);
        chk({30'h0, phase_pol}, 32'h2);
        u_ctrl.step(1'b1, 2'b10, 1'b1);
        pos_chk(9'h0D0);
        chk({30'h0, rd[21:20]}, 32'h2);
        chk({30'h0, phase_level[0] > HOME_LVL, phase_level[1] < HOME_LVL}, 32'h3);
        u_ctrl.step(1'b0, 2'b10, 1'b1);
        pos_chk(9'h0C0);
        chk({30'h0, rd[21:20]}, 32'h1);
        chk({16'h0000, phase_level[1], phase_level[0]}, {16'h0000, HOME_LVL, HOME_LVL});
        @(posedge hclk);
        thermal_shutdown <= 1'b1;
        repeat (3) @(posedge hclk);
        thermal_shutdown <= 1'b0;
        pos_chk(9'h040);
        u_ctrl.step(1'b1, 2'b00, 1'b1);
        overcurrent <= 1'b1;
        repeat (3) @(posedge hclk);
        overcurrent <= 1'b0;
        pos_chk(9'h040);
        $display("test decay and faults done");
    endtask : t_decay
    task automatic t_chop;
        ahb(1'b1, 32'h0, 32'h0, rd);
        chop(0, OFF_T * 5 / 16, OFF_T);
        chop(1, OFF_T * 5 / 16, OFF_T);
        ahb(1'b1, 32'h0, 32'h0000_0001, rd);
        chop(0, 0, OFF_T);
        ahb(1'b1, 32'h0, 32'h0000_0202, rd);
        chop(1, 0, 2 * CYC_PER_US);
        @(posedge hclk);
        output_disable <= 1'b1;
        u_ctrl.step(1'b1, 2'b00, 1'b1);
        chk({30'h0, bridge_drive}, 32'h0);
        pos_chk(9'h0C0);
        output_disable <= 1'b0;
        $display("test chopper done");
    endtask : t_chop
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    initial begin
        {hresetn, hsel, hwrite, thermal_shutdown, overcurrent, output_disable} = '0;
        {haddr, hwdata, htrans, cmp_trip, cycles, bad_count, total_checks} = '0;
        hsize              = 3'h2;
        translator_reset_n = 1'b1;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_home();
        t_res();
        t_decay();
        t_chop();
        conclude();
    end
endmodule : microstep_translator_chopper_tb
`default_nettype wire
